// File: core/alc_edge_sync.v
`timescale 1ns/10ps
// two-flop synchroniser with registered edge pulses
module alc_edge_sync (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // asynchronous pin
  input wire pin_in,
  // synchronised level and edges
  output wire level,
  output reg rise,
  output reg fall
);
  reg meta_q;
  reg sync_q;
  reg last_q;
  assign level = sync_q;
  // first flop feeds only the second
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      last_q <= sync_q;
      rise <= sync_q & ~last_q;
      fall <= ~sync_q & last_q;
    end
  end
endmodule

// File: core/alc_layer_ctrl.v
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`include "alc_consts.vh"
// Summary of operation
// [R1] nothing runs unless configuration bit 0 enables the layer
// [R2] bits 3:2 pick list pacer: 01 software, 10 internal, 11 external
// [R3] list period split evenly so each channel settles longest
// [R4] upper pacer bit with lower selects the external chassis sync line
// [R5] bits 7:6 start, 9:8 stop trigger: 00 software, 01 rise, 10 fall
// [R6] first read request halts acquisition and reloads the channel list
// [R7] default list rate after first read request is 10 Hz
// [R8] reprogramming finishes within 10 ms; host waits at least that
// [R9] then acquire continuously, reads return latest value per channel
// [R10] host builds entries as gain code ORed with channel number
// [R11] trigger code 11 behaves like software trigger
// [R12] while disabled, ignore edges and ticks, hold sequencer at entry 0
module alc_layer_ctrl (
  // apb slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // external pins
  input wire trig_pin,
  input wire chassis_sync_line,
  // converter interface
  output reg conv_start,
  output reg [`ALC_ENT_CH_W-1:0] conv_chan,
  output reg [`ALC_ENT_GAIN_W-1:0] conv_gain,
  input wire conv_done,
  input wire [15:0] conv_data,
  // status
  output wire acq_running,
  output wire reprog_busy
);
  // ************************************************************
  // registers and storage
  // ************************************************************
  reg [31:0] cfg_q;
  reg [31:0] period_q;
  reg [`ALC_IDX_W-1:0] len_q;
  reg [15:0] list_q [0:`ALC_LIST_DEPTH-1];
  reg [15:0] data_q [0:`ALC_LIST_DEPTH-1];
  reg [15:0] shadow_q [0:`ALC_LIST_DEPTH-1];
  reg [`ALC_IDX_W-1:0] shadow_len_q;
  reg running_q;
  reg first_done_q;
  reg [31:0] reprog_cnt_q;
  reg [31:0] list_cnt_q;
  reg [31:0] slot_cnt_q;
  reg [31:0] slot_len_q;
  reg [`ALC_IDX_W-1:0] idx_q;
  reg in_list_q;
  reg conv_busy_q;
  integer cfg_i;
  integer run_i;
  integer dat_i;
  wire trig_lvl;
  wire trig_rise;
  wire trig_fall;
  wire sync_lvl;
  wire sync_rise;
  wire wr_en;
  wire en;
  wire [1:0] cl_src;
  wire [1:0] st_sel;
  wire [1:0] sp_sel;
  wire sw_start;
  wire sw_stop;
  wire sw_read;
  wire sw_tick;
  wire hw_start;
  wire hw_stop;
  wire list_tick;
  wire reprog;
  wire slot_due;
  wire [`ALC_IDX_W-1:0] waddr;
  wire [`ALC_IDX_W-1:0] ridx;
  // ************************************************************
  // helper functions
  // ************************************************************
  // edge match for a trigger field, code 11 never fires
  function edge_hit;
    input [1:0] sel;
    input r;
    input f;
    begin
      edge_hit = (sel == `ALC_TRG_RISE) ? r : (sel == `ALC_TRG_FALL) ? f : 1'b0; // R5 R11
    end
  endfunction
  // word index inside a table window, counted from its base
  function [`ALC_IDX_W-1:0] tbl_idx;
    input [11:0] a;
    input [11:0] base;
    reg [11:0] off;
    begin
      off = a - base;
      tbl_idx = off[`ALC_IDX_W+1:2];
    end
  endfunction
  // address lies inside a table window, so no entry aliases another table
  function tbl_hit;
    input [11:0] a;
    input [11:0] base;
    begin
      tbl_hit = (a >= base) && (a < base + `ALC_TBL_BYTES);
    end
  endfunction
  // ************************************************************
  // pin synchronisers
  // ************************************************************
  alc_edge_sync u_trig (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(trig_pin),
    .level(trig_lvl),
    .rise(trig_rise),
    .fall(trig_fall)
  );
  alc_edge_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(chassis_sync_line),
    .level(sync_lvl),
    .rise(sync_rise),
    .fall()
  );
  // ************************************************************
  // decode
  // ************************************************************
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en = psel & penable & pwrite;
  assign waddr = tbl_idx(paddr, `ALC_OFS_LIST);
  assign ridx = tbl_idx(paddr, `ALC_OFS_DATA);
  assign en = cfg_q[`ALC_CFG_EN]; // R1
  assign cl_src = cfg_q[`ALC_CFG_CL_LO+1:`ALC_CFG_CL_LO]; // R2
  assign st_sel = cfg_q[`ALC_CFG_ST_LO+1:`ALC_CFG_ST_LO];
  assign sp_sel = cfg_q[`ALC_CFG_SP_LO+1:`ALC_CFG_SP_LO];
  assign sw_start = wr_en & (paddr == `ALC_OFS_CMD) & pwdata[`ALC_CMD_START];
  assign sw_stop = wr_en & (paddr == `ALC_OFS_CMD) & pwdata[`ALC_CMD_STOP];
  assign sw_read = wr_en & (paddr == `ALC_OFS_CMD) & pwdata[`ALC_CMD_READ];
  assign sw_tick = wr_en & (paddr == `ALC_OFS_CMD) & pwdata[`ALC_CMD_TICK];
  assign hw_start = en & edge_hit(st_sel, trig_rise, trig_fall); // R5 R12
  assign hw_stop = en & edge_hit(sp_sel, trig_rise, trig_fall); // R5 R12
  assign reprog = en & sw_read & ~first_done_q; // R6
  // pacer tick by source; unknown code 00 never ticks
  assign list_tick = en & running_q & ~in_list_q & // R12
    (((cl_src == `ALC_SRC_SW) & sw_tick) | // R2
     ((cl_src == `ALC_SRC_HW) & (list_cnt_q == 32'h0000_0000)) |
     ((cl_src == `ALC_SRC_EXT) & sync_rise)); // R4
  assign slot_due = in_list_q & ~conv_busy_q & (slot_cnt_q == 32'h0000_0000);
  assign acq_running = running_q;
  assign reprog_busy = (reprog_cnt_q != 32'h0000_0000);
  // ************************************************************
  // configuration registers and list table
  // ************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= `ALC_CFG_RST;
      period_q <= `ALC_DEF_PERIOD;
      len_q <= {`ALC_IDX_W{1'b0}};
      for (cfg_i = 0; cfg_i < `ALC_LIST_DEPTH; cfg_i = cfg_i + 1) begin
        list_q[cfg_i] <= 16'h0000;
      end
    end else begin
      if (wr_en && paddr == `ALC_OFS_CFG) begin
        cfg_q <= pwdata;
      end
      if (wr_en && paddr == `ALC_OFS_RATE && pwdata != 32'h0000_0000) begin
        period_q <= pwdata; // nonzero rate write, taken before or after the first read
      end else if (reprog) begin
        period_q <= `ALC_DEF_PERIOD; // R7
      end
      // a length whose low five bits lie past the table is refused so the sequencer never leaves it
      if (wr_en && paddr == `ALC_OFS_LEN && pwdata[`ALC_IDX_W-1:0] < `ALC_LIST_DEPTH) begin
        len_q <= pwdata[`ALC_IDX_W-1:0];
      end
      if (wr_en && tbl_hit(paddr, `ALC_OFS_LIST)) begin
        list_q[waddr] <= pwdata[15:0]; // R10
      end
    end
  end
  // ************************************************************
  // run control and reprogramming
  // ************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      running_q <= 1'b0;
      first_done_q <= 1'b0;
      reprog_cnt_q <= 32'h0000_0000;
      shadow_len_q <= {`ALC_IDX_W{1'b0}};
      for (run_i = 0; run_i < `ALC_LIST_DEPTH; run_i = run_i + 1) begin
        shadow_q[run_i] <= 16'h0000;
      end
    end else begin
      if (!en) begin
        running_q <= 1'b0; // R1
        first_done_q <= 1'b0;
        reprog_cnt_q <= 32'h0000_0000;
      end else if (reprog) begin
        running_q <= 1'b0; // R6
        first_done_q <= 1'b1;
        reprog_cnt_q <= `ALC_REPROG_CYC - 1; // R8
        shadow_len_q <= len_q;
        for (run_i = 0; run_i < `ALC_LIST_DEPTH; run_i = run_i + 1) begin
          shadow_q[run_i] <= list_q[run_i];
        end
      end else if (reprog_busy) begin
        reprog_cnt_q <= reprog_cnt_q - 32'h0000_0001;
        if (reprog_cnt_q == 32'h0000_0001) begin
          running_q <= 1'b1; // R9
        end
      end else if (hw_stop || (sw_stop && sp_sel != `ALC_TRG_RISE && sp_sel != `ALC_TRG_FALL)) begin
        running_q <= 1'b0; // R11
      end else if (hw_start || (sw_start && st_sel != `ALC_TRG_RISE && st_sel != `ALC_TRG_FALL)) begin
        running_q <= 1'b1; // R11
        // a start from idle runs the list as it stands; never reload mid list
        if (!running_q) begin
          shadow_len_q <= len_q;
          for (run_i = 0; run_i < `ALC_LIST_DEPTH; run_i = run_i + 1) begin
            shadow_q[run_i] <= list_q[run_i];
          end
        end
      end
    end
  end
  // ************************************************************
  // list sequencer
  // ************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      list_cnt_q <= 32'h0000_0000;
      slot_cnt_q <= 32'h0000_0000;
      slot_len_q <= 32'h0000_0000;
      idx_q <= {`ALC_IDX_W{1'b0}};
      in_list_q <= 1'b0;
      conv_busy_q <= 1'b0;
      conv_start <= 1'b0;
      conv_chan <= {`ALC_ENT_CH_W{1'b0}};
      conv_gain <= {`ALC_ENT_GAIN_W{1'b0}};
    end else begin
      conv_start <= 1'b0;
      if (!en || !running_q) begin
        idx_q <= {`ALC_IDX_W{1'b0}}; // R12
        in_list_q <= 1'b0;
        conv_busy_q <= 1'b0;
        list_cnt_q <= 32'h0000_0000;
      end else begin
        list_cnt_q <= (list_cnt_q == 32'h0000_0000) ? period_q - 32'h0000_0001 : list_cnt_q - 32'h0000_0001;
        if (list_tick) begin
          in_list_q <= 1'b1;
          idx_q <= {`ALC_IDX_W{1'b0}};
          slot_len_q <= period_q / {27'h000_0000, shadow_len_q + 5'h01}; // R3
          slot_cnt_q <= 32'h0000_0000;
        end else if (in_list_q) begin
          if (slot_cnt_q != 32'h0000_0000) begin
            slot_cnt_q <= slot_cnt_q - 32'h0000_0001;
          end
          if (slot_due) begin
            conv_start <= 1'b1; // R3
            conv_chan <= shadow_q[idx_q][`ALC_ENT_CH_W-1:0]; // R10
            conv_gain <= shadow_q[idx_q][`ALC_ENT_GAIN_LO+`ALC_ENT_GAIN_W-1:`ALC_ENT_GAIN_LO];
            conv_busy_q <= 1'b1;
            slot_cnt_q <= slot_len_q;
          end else if (conv_busy_q && conv_done) begin
            conv_busy_q <= 1'b0;
            if (idx_q == shadow_len_q) begin
              in_list_q <= 1'b0;
              idx_q <= {`ALC_IDX_W{1'b0}};
            end else begin
              idx_q <= idx_q + 5'h01;
            end
          end
        end
      end
    end
  end
  // ************************************************************
  // latest data per list entry
  // ************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (dat_i = 0; dat_i < `ALC_LIST_DEPTH; dat_i = dat_i + 1) begin
        data_q[dat_i] <= 16'h0000;
      end
    end else if (in_list_q && conv_busy_q && conv_done && !slot_due) begin
      data_q[idx_q] <= conv_data; // R9
    end
  end
  // ************************************************************
  // apb read data
  // ************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == `ALC_OFS_CFG) begin
        prdata <= cfg_q;
      end else if (paddr == `ALC_OFS_RATE) begin
        prdata <= period_q;
      end else if (paddr == `ALC_OFS_STAT) begin
        prdata <= {27'h000_0000, trig_lvl, sync_lvl, first_done_q, reprog_busy, running_q};
      end else if (paddr == `ALC_OFS_LEN) begin
        prdata <= {27'h000_0000, len_q};
      end else if (tbl_hit(paddr, `ALC_OFS_LIST)) begin
        prdata <= {16'h0000, list_q[waddr]};
      end else if (tbl_hit(paddr, `ALC_OFS_DATA)) begin
        prdata <= {16'h0000, data_q[ridx]}; // R9
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end
endmodule

// File: include/alc_consts.vh
`ifndef ALC_CONSTS_VH
`define ALC_CONSTS_VH
// ************************************************************
// register offsets (byte addresses)
// ************************************************************
`define ALC_OFS_CFG 12'h000
`define ALC_OFS_RATE 12'h004
`define ALC_OFS_CMD 12'h008
`define ALC_OFS_STAT 12'h00c
`define ALC_OFS_LEN 12'h010
`define ALC_OFS_LIST 12'h040
`define ALC_OFS_DATA 12'h0a0
// byte span of one table window, one word per list entry
`define ALC_TBL_BYTES 12'h060
// ************************************************************
// configuration word fields
// ************************************************************
`define ALC_CFG_EN 0
`define ALC_CFG_CL_LO 2
`define ALC_CFG_ST_LO 6
`define ALC_CFG_SP_LO 8
`define ALC_SRC_SW 2'b01
`define ALC_SRC_HW 2'b10
`define ALC_SRC_EXT 2'b11
`define ALC_TRG_SW 2'b00
`define ALC_TRG_RISE 2'b01
`define ALC_TRG_FALL 2'b10
// ************************************************************
// channel list entry fields
// ************************************************************
`define ALC_ENT_CH_W 5
`define ALC_ENT_GAIN_LO 8
`define ALC_ENT_GAIN_W 2
`define ALC_LIST_DEPTH 24
`define ALC_IDX_W 5
// ************************************************************
// reset values and timing
// ************************************************************
`define ALC_CFG_RST 32'h0000_0000
`define ALC_CLK_HZ 50000000
`define ALC_DEF_RATE_HZ 10
`define ALC_DEF_PERIOD (`ALC_CLK_HZ / `ALC_DEF_RATE_HZ)
`define ALC_REPROG_MS 10
`define ALC_REPROG_CYC (`ALC_CLK_HZ / 1000 * `ALC_REPROG_MS)
`define ALC_CMD_START 0
`define ALC_CMD_STOP 1
`define ALC_CMD_READ 2
`define ALC_CMD_TICK 3
`endif

// File: testbench/alc_layer_monitor.sv
`timescale 1ns/10ps
`include "alc_consts.vh"
// ****
// port checks for the layer control block
// ****
module alc_layer_monitor (
  // apb
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // acquisition
  input wire conv_start,
  input wire acq_running,
  input wire reprog_busy
);
  reg en_q;
  reg [19:0] busy_q;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // shadow enable bit and length of the busy interval
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= 1'b0;
      busy_q <= 20'h0_0000;
    end else begin
      if (psel && penable && pwrite && paddr == `ALC_OFS_CFG) en_q <= pwdata[0];
      busy_q <= reprog_busy ? busy_q + 20'h0_0001 : 20'h0_0000;
    end
  end
  a_zero_wait: assert property (pready && !pslverr)
    else $error("pready low or pslverr high");
  a_pulse_single: assert property (conv_start |=> !conv_start)
    else $error("conversion start longer than one cycle");
  a_busy_halts: assert property (reprog_busy |-> !acq_running)
    else $error("running while reprogramming");
  a_reprog_bound: assert property (busy_q <= `ALC_REPROG_CYC)
    else $error("reprogramming too long");
  a_disable_stops: assert property (!en_q |-> ##1 !acq_running)
    else $error("running while disabled");
  a_disable_quiet: assert property (!en_q |-> ##2 !conv_start)
    else $error("conversion while disabled");
  a_unmapped_zero: assert property ((psel && penable && !pwrite && paddr[11:8] != 4'h0) |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_stat_mirror: assert property ((psel && !penable && !pwrite && paddr == `ALC_OFS_STAT)
    |=> prdata[1:0] == $past({reprog_busy, acq_running}))
    else $error("status bits differ from outputs");
  a_conv_running: assert property (conv_start |-> (acq_running || $past(acq_running)))
    else $error("conversion while stopped");
endmodule

// File: testbench/tb_alc_layer_ctrl.sv
`timescale 1ns/10ps
`include "alc_consts.vh"
// ****
// register level bench
// ****
module tb_alc_layer_ctrl;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic trig_pin = 1'b0, chassis_sync_line = 1'b0, conv_done = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, rd;
  logic [15:0] conv_data = 16'h0000;
  wire [31:0] prdata;
  wire pready, pslverr, conv_start, acq_running, reprog_busy;
  wire [4:0] conv_chan;
  wire [1:0] conv_gain;
  int errors = 0, num_checks = 0;
  // 50 MHz clock
  always #10 pclk = ~pclk;
  alc_layer_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trig_pin(trig_pin), .chassis_sync_line(chassis_sync_line), .conv_start(conv_start),
    .conv_chan(conv_chan), .conv_gain(conv_gain), .conv_done(conv_done), .conv_data(conv_data),
    .acq_running(acq_running), .reprog_busy(reprog_busy));
  // compare and count
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task close_out;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one apb transfer, held until pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      errors++;
      close_out();
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk($sformatf("reg %h", a), rd, e);
  endtask
  task run(input logic e);
    repeat (8) @(negedge pclk);
    chk("running", {31'h0, acq_running}, {31'h0, e});
  endtask
  task pin(input logic v);
    @(posedge pclk);
    trig_pin <= v;
    repeat (8) @(posedge pclk);
  endtask
  // wait for a conversion of entry 0, then answer it
  task conv(input logic [15:0] d);
    int n;
    n = 0;
    while (conv_start !== 1'b1 && n < 400) begin
      @(negedge pclk);
      n++;
    end
    chk("conv start", {31'h0, n < 400}, 32'h1);
    if (n >= 400) close_out();
    chk("chan", {27'h0, conv_chan}, 32'h7);
    chk("gain", {30'h0, conv_gain}, 32'h2);
    @(posedge pclk);
    conv_done <= 1'b1;
    conv_data <= d;
    chassis_sync_line <= 1'b0;
    @(posedge pclk);
    conv_done <= 1'b0;
    rc(`ALC_OFS_DATA, {16'h0000, d});
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rc(`ALC_OFS_CFG, 32'h0000_0000);
    rc(`ALC_OFS_RATE, 32'h004c_4b40);
    rc(`ALC_OFS_STAT, 32'h0000_0000);
    wr(12'h100, 32'hffff_ffff);
    rc(12'h100, 32'h0000_0000);
    wr(`ALC_OFS_RATE, 32'h0000_0000);
    rc(`ALC_OFS_RATE, 32'h004c_4b40);
    wr(`ALC_OFS_RATE, 32'h0000_0040);
    wr(`ALC_OFS_LEN, 32'h0000_0000);
    wr(`ALC_OFS_LIST, 32'h0000_0207);
    rc(`ALC_OFS_LIST, 32'h0000_0207);
    wr(`ALC_OFS_CFG, 32'h0000_0044);
    pin(1'b1);
    pin(1'b0);
    run(1'b0);
    wr(`ALC_OFS_CFG, 32'h0000_0004);
    wr(`ALC_OFS_CMD, 32'h0000_0001);
    run(1'b0);
    wr(`ALC_OFS_CFG, 32'h0000_0005);
    wr(`ALC_OFS_CMD, 32'h0000_0001);
    run(1'b1);
    wr(`ALC_OFS_CMD, 32'h0000_0008);
    conv(16'h1234);
    wr(`ALC_OFS_CFG, 32'h0000_000d);
    @(posedge pclk);
    chassis_sync_line <= 1'b1;
    conv(16'habcd);
    wr(`ALC_OFS_CMD, 32'h0000_0002);
    run(1'b0);
    for (int c = 1; c < 3; c++) begin
      wr(`ALC_OFS_CFG, 32'h0000_0001);
      pin(c == 2);
      wr(`ALC_OFS_CFG, 32'h0000_0001 | (32'(c) << 6));
      pin(c != 2);
      run(1'b1);
      wr(`ALC_OFS_CMD, 32'h0000_0002);
      wr(`ALC_OFS_CFG, 32'h0000_0001);
      pin(c == 2);
      wr(`ALC_OFS_CFG, 32'h0000_0001 | (32'(c) << 8));
      wr(`ALC_OFS_CMD, 32'h0000_0001);
      run(1'b1);
      pin(c != 2);
      run(1'b0);
    end
    wr(`ALC_OFS_CFG, 32'h0000_03c1);
    pin(1'b1);
    pin(1'b0);
    run(1'b0);
    wr(`ALC_OFS_CMD, 32'h0000_0001);
    run(1'b1);
    wr(`ALC_OFS_CMD, 32'h0000_0004);
    run(1'b0);
    chk("busy", {31'h0, reprog_busy}, 32'h1);
    rc(`ALC_OFS_RATE, 32'h004c_4b40);
    wr(`ALC_OFS_CFG, 32'h0000_0000);
    run(1'b0);
    close_out();
  end
endmodule
// checker on the block's ports
bind alc_layer_ctrl alc_layer_monitor i_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .conv_start(conv_start), .acq_running(acq_running), .reprog_busy(reprog_busy));
